//--- rtl/iocpr_defines.svh
// Offsets, field positions, reset values and timing counts of the configuration bank
`ifndef IOCPR_DEFINES_SVH
`define IOCPR_DEFINES_SVH
// Host port addresses
`define IOCPR_INDEX_PORT    10'h251
`define IOCPR_DATA_PORT     10'h252
// Register indexes
`define IOCPR_IDX_PWR_SEL   8'h00
`define IOCPR_IDX_SWAP      8'h01
`define IOCPR_IDX_ADAPTER   8'h02
`define IOCPR_IDX_UART_PIN  8'h03
`define IOCPR_IDX_PORT_PWR  8'h04
`define IOCPR_IDX_ECP       8'h05
`define IOCPR_IDX_FLOPPY    8'h06
// Writable bit masks
`define IOCPR_MASK_PWR_SEL  8'h0f
`define IOCPR_MASK_SWAP     8'h80
`define IOCPR_MASK_ADAPTER  8'hff
`define IOCPR_MASK_UART_PIN 8'h33
`define IOCPR_MASK_PORT_PWR 8'hff
`define IOCPR_MASK_ECP      8'h0f
`define IOCPR_MASK_FLOPPY   8'h7f
// Reset values
`define IOCPR_RST_PWR_SEL   8'h00
`define IOCPR_RST_SWAP      8'h00
`define IOCPR_RST_ADAPTER   8'h00
`define IOCPR_RST_UART_PIN  8'h30
`define IOCPR_RST_PORT_PWR  8'h00
`define IOCPR_RST_ECP       8'h00
`define IOCPR_RST_FLOPPY    8'h00
// Field positions
`define IOCPR_BIT_SWAP      7
`define IOCPR_BIT_CMP_WIDTH 0
`define IOCPR_BIT_UART2_MID 0
`define IOCPR_BIT_UART1_MID 1
`define IOCPR_BIT_PIN_ROLE  4
`define IOCPR_BIT_EPP_REV   5
`define IOCPR_BIT_PSEL_HI   6
`define IOCPR_BIT_FOUR_DRV  5
`define IOCPR_BIT_PULLUP    4
`define IOCPR_BIT_FDC_PD    3
`define IOCPR_BIT_IDE_PD    2
`define IOCPR_BIT_FDC_TRI   1
`define IOCPR_BIT_IDE_TRI   0
// Power select codes and parallel mode
`define IOCPR_PSEL_STANDBY  3'b010
`define IOCPR_APD_ASLEEP    2'b11
`define IOCPR_APD_STANDBY   2'b10
`define IOCPR_PMODE_ADAPTER 3'b010
// UART divisors
`define IOCPR_DIV_NORMAL    4'hd
`define IOCPR_DIV_MIDI      4'hc
// Idle countdown: 4 s at a 100 ns clock period
`define IOCPR_APD_TIME_MS   4000
`define IOCPR_CLK_PERIOD_NS 100
`define IOCPR_APD_CYCLES    (`IOCPR_APD_TIME_MS * (1000000 / `IOCPR_CLK_PERIOD_NS))
`endif

//--- rtl/iocpr_pkg.sv
// Types shared by the configuration bank
package iocpr_pkg;
    typedef enum logic [1:0] {APD_NORMAL, APD_COUNT, APD_ASLEEP} iocpr_apd_e;
    typedef logic [7:0] iocpr_byte_t;
    typedef logic [9:0] iocpr_addr_t;
endpackage : iocpr_pkg

//--- rtl/iocpr_regs.sv
// Indexed configuration and power register bank
`timescale 1ns/1ps
`include "iocpr_defines.svh"

// Summary of operation
// - Standby countdown expiry sets code 11, stops clock
// - Idle change while asleep restarts clock, code 10
// - Wake resumes operation next cycle, no delay
// - Swap bit exchanges drive A and B
// - Base write in adapter mode pulses both strobes
// - Matching host cycle pulses read or write strobe
// - Compare bits 9..3, or 9..4 when width set
// - Second UART divides by 13, or 12
// - First UART divides by 13, or 12
// - Pin role picks portable or game strobes
// - Pin role honoured only with game DMA bit
// - EPP revision select, 1.7 by default
// - Four port power-down bits, default powered
// - Port float only while that port powered down
// - Four-bit ECP FIFO threshold, reset zero
// - High power-select bit joins two low bits
// - Two-drive mode decodes A and B, active low
// - Four-drive mode encodes drive number, motors low
// - Pull-up off bit disables floppy input pull-ups
// - Floppy and disk interface power-down bits
// - Floppy and disk float only while powered down
// - Idle countdown restarts on any condition change
module iocpr_regs #(
    parameter int APD_CYCLES = `IOCPR_APD_CYCLES
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Host I/O bus
    input  wire logic              ext_mode,
    input  wire iocpr_pkg::iocpr_addr_t io_addr,
    input  wire iocpr_pkg::iocpr_byte_t io_wdata,
    input  wire logic              io_wr,
    input  wire logic              io_rd,
    output iocpr_pkg::iocpr_byte_t io_rdata_ff,
    // Device state inputs
    input  wire logic              idle_ok,
    input  wire logic              prt_mode_hi,
    input  wire logic              game_dma_request_bit,
    input  wire iocpr_pkg::iocpr_byte_t dor,
    // Shared pin sources
    input  wire logic              portable_floppy_enable,
    input  wire logic              portable_ext_enable,
    input  wire logic              game_read_strobe,
    input  wire logic              game_write_strobe,
    // Power and clock control
    output logic                   internal_clock_stop_ff,
    output logic [2:0]             power_select_ff,
    // Extension adapter
    output logic                   adapter_read_strobe_n_ff,
    output logic                   adapter_write_strobe_n_ff,
    output iocpr_pkg::iocpr_byte_t adapter_data_ff,
    // UART clocks, pins and parallel port
    output logic [3:0]             uart1_divisor_ff,
    output logic [3:0]             uart2_divisor_ff,
    output logic                   pin41_ff,
    output logic                   pin39_ff,
    output logic                   pin_role_game_ff,
    output logic                   epp_revision_select_ff,
    output logic [3:0]             ecp_fifo_level_ff,
    // Port power and float
    output logic                   par_power_down_ff,
    output logic                   game_power_down_ff,
    output logic                   uart1_power_down_ff,
    output logic                   uart2_power_down_ff,
    output logic                   par_float_outputs_ff,
    output logic                   game_float_outputs_ff,
    output logic                   uart1_float_outputs_ff,
    output logic                   uart2_float_outputs_ff,
    // Floppy and disk interface
    output logic                   floppy_pullup_off_ff,
    output logic                   floppy_power_down_ff,
    output logic                   disk_if_power_down_ff,
    output logic                   floppy_float_outputs_ff,
    output logic                   disk_if_float_outputs_ff,
    output logic                   drive_select_line0_n_ff,
    output logic                   drive_select_line1_n_ff,
    output logic                   motor_line0_n_ff,
    output logic                   motor_line1_n_ff
);
    import iocpr_pkg::*;

    // ----------------------------------------
    // Register storage and decode
    // ----------------------------------------
    logic [7:0]  index_ff;
    logic [3:0]  pwr_sel_ff;
    logic        drive_swap_ff;
    logic [7:0]  adapter_base_ff;
    logic [7:0]  uart_pin_ff;
    logic [7:0]  port_pwr_ff;
    logic [3:0]  ecp_ff;
    logic [6:0]  floppy_ff;
    iocpr_apd_e  apd_state_ff;
    logic [25:0] apd_cnt_ff;
    logic        idx_wr;
    logic        cfg_wr;
    logic        cfg_rd;
    logic        idle;
    logic [2:0]  psel;
    logic        apd_enter;
    logic        apd_wake;
    logic        adapter_mode;
    logic        base_wr;
    logic        addr_match;
    logic [7:0]  rd_mux;
    logic [7:0]  eff_dor;

    // Port decodes; data port accesses the held index, 00 after reset
    assign idx_wr = io_wr && ext_mode && (io_addr == `IOCPR_INDEX_PORT);
    assign cfg_wr = io_wr && ext_mode && (io_addr == `IOCPR_DATA_PORT);
    assign cfg_rd = io_rd && ext_mode && (io_addr == `IOCPR_DATA_PORT);

    // Index register
    always_ff @(posedge clk) begin
        if (rst) begin
            index_ff <= 8'h00;
        end else if (idx_wr) begin
            index_ff <= io_wdata;
        end
    end

    // Power select low bits and parallel mode; hardware update wins over host write
    always_ff @(posedge clk) begin
        if (rst) begin
            pwr_sel_ff <= 4'(`IOCPR_RST_PWR_SEL);
        end else begin
            if (cfg_wr && index_ff == `IOCPR_IDX_PWR_SEL) begin
                pwr_sel_ff <= 4'(io_wdata & `IOCPR_MASK_PWR_SEL);
            end
            if (apd_enter) begin
                pwr_sel_ff[1:0] <= `IOCPR_APD_ASLEEP;
            end else if (apd_wake) begin
                pwr_sel_ff[1:0] <= `IOCPR_APD_STANDBY;
            end
        end
    end

    // Host-written configuration registers, reserved bits masked off
    always_ff @(posedge clk) begin
        if (rst) begin
            drive_swap_ff   <= 1'b0;
            adapter_base_ff <= `IOCPR_RST_ADAPTER;
            uart_pin_ff     <= `IOCPR_RST_UART_PIN;
            port_pwr_ff     <= `IOCPR_RST_PORT_PWR;
            ecp_ff          <= 4'(`IOCPR_RST_ECP);
            floppy_ff       <= 7'(`IOCPR_RST_FLOPPY);
        end else if (cfg_wr) begin
            case (index_ff)
                `IOCPR_IDX_SWAP:     drive_swap_ff   <= io_wdata[`IOCPR_BIT_SWAP];
                `IOCPR_IDX_ADAPTER:  adapter_base_ff <= io_wdata & `IOCPR_MASK_ADAPTER;
                `IOCPR_IDX_UART_PIN: uart_pin_ff     <= io_wdata & `IOCPR_MASK_UART_PIN;
                `IOCPR_IDX_PORT_PWR: port_pwr_ff     <= io_wdata & `IOCPR_MASK_PORT_PWR;
                `IOCPR_IDX_ECP:      ecp_ff          <= io_wdata[3:0];
                `IOCPR_IDX_FLOPPY:   floppy_ff       <= io_wdata[6:0];
                default: begin
                end
            endcase
        end
    end

    // Read data mux; unmapped indexes and reserved bits read zero
    always_comb begin
        case (index_ff)
            `IOCPR_IDX_PWR_SEL:  rd_mux = {4'h0, pwr_sel_ff};
            `IOCPR_IDX_SWAP:     rd_mux = {drive_swap_ff, 7'h00};
            `IOCPR_IDX_ADAPTER:  rd_mux = adapter_base_ff;
            `IOCPR_IDX_UART_PIN: rd_mux = uart_pin_ff;
            `IOCPR_IDX_PORT_PWR: rd_mux = port_pwr_ff;
            `IOCPR_IDX_ECP:      rd_mux = {4'h0, ecp_ff};
            `IOCPR_IDX_FLOPPY:   rd_mux = {1'b0, floppy_ff};
            default:             rd_mux = 8'h00;
        endcase
    end

    // Registered read data, zero when no data port read
    always_ff @(posedge clk) begin
        if (rst) begin
            io_rdata_ff <= 8'h00;
        end else begin
            io_rdata_ff <= cfg_rd ? rd_mux : 8'h00;
        end
    end

    // ----------------------------------------
    // Automatic power-down
    // ----------------------------------------
    assign psel      = {floppy_ff[`IOCPR_BIT_PSEL_HI], pwr_sel_ff[1:0]};
    assign idle      = idle_ok && !io_rd && !io_wr;
    assign apd_enter = (apd_state_ff == APD_COUNT) && idle && (psel == `IOCPR_PSEL_STANDBY)
                       && (apd_cnt_ff == 26'h0000000);
    assign apd_wake  = (apd_state_ff == APD_ASLEEP) && !idle;

    // Idle countdown state machine
    always_ff @(posedge clk) begin
        if (rst) begin
            apd_state_ff <= APD_NORMAL;
            apd_cnt_ff   <= 26'h0000000;
        end else begin
            case (apd_state_ff)
                APD_NORMAL: begin
                    if (idle && psel == `IOCPR_PSEL_STANDBY) begin
                        apd_state_ff <= APD_COUNT;
                        apd_cnt_ff   <= 26'(APD_CYCLES - 1);
                    end
                end
                APD_COUNT: begin
                    if (!idle || psel != `IOCPR_PSEL_STANDBY) begin
                        apd_state_ff <= APD_NORMAL;
                    end else if (apd_enter) begin
                        apd_state_ff <= APD_ASLEEP;
                    end else begin
                        apd_cnt_ff <= apd_cnt_ff - 26'h0000001;
                    end
                end
                APD_ASLEEP: begin
                    if (apd_wake) begin
                        apd_state_ff <= APD_NORMAL;
                    end
                end
                default: apd_state_ff <= APD_NORMAL;
            endcase
        end
    end

    // Clock gate follows the sleep state with no settling wait
    always_ff @(posedge clk) begin
        if (rst) begin
            internal_clock_stop_ff <= 1'b0;
            power_select_ff        <= 3'b000;
        end else begin
            internal_clock_stop_ff <= apd_enter || (apd_state_ff == APD_ASLEEP && !apd_wake);
            power_select_ff        <= psel;
        end
    end

    AST_APD_ENTER: assert property (@(posedge clk) disable iff (rst)
        apd_enter |=> (pwr_sel_ff[1:0] == 2'b11) && internal_clock_stop_ff)
        else $error("Countdown expiry did not enter sleep");
    AST_APD_WAKE: assert property (@(posedge clk) disable iff (rst)
        apd_wake |=> (pwr_sel_ff[1:0] == 2'b10) && !internal_clock_stop_ff)
        else $error("Wake did not restore standby code");
    AST_APD_RESTART: assert property (@(posedge clk) disable iff (rst)
        (apd_state_ff == APD_COUNT) && !idle |=> (apd_state_ff == APD_NORMAL) && !internal_clock_stop_ff)
        else $error("Countdown not restarted on activity");

    // ----------------------------------------
    // Extension adapter strobes
    // ----------------------------------------
    assign adapter_mode = ({prt_mode_hi, pwr_sel_ff[3:2]} == `IOCPR_PMODE_ADAPTER);
    assign base_wr      = cfg_wr && (index_ff == `IOCPR_IDX_ADAPTER);
    assign addr_match   = adapter_base_ff[`IOCPR_BIT_CMP_WIDTH]
                          ? (io_addr[9:4] == adapter_base_ff[7:2])
                          : (io_addr[9:3] == adapter_base_ff[7:1]);

    // Strobes pulse low for one cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            adapter_read_strobe_n_ff  <= 1'b1;
            adapter_write_strobe_n_ff <= 1'b1;
            adapter_data_ff           <= 8'h00;
        end else begin
            adapter_read_strobe_n_ff  <= !(adapter_mode && (base_wr || (io_rd && addr_match)));
            adapter_write_strobe_n_ff <= !(adapter_mode && (base_wr || (io_wr && addr_match)));
            if (adapter_mode && base_wr) begin
                adapter_data_ff <= io_wdata;
            end
        end
    end

    AST_BASE_LATCH: assert property (@(posedge clk) disable iff (rst)
        adapter_mode && base_wr |=> !adapter_read_strobe_n_ff && !adapter_write_strobe_n_ff)
        else $error("Base write did not pulse both strobes");
    AST_MATCH_RD: assert property (@(posedge clk) disable iff (rst)
        adapter_mode && io_rd && !adapter_base_ff[0] && (io_addr[9:3] == adapter_base_ff[7:1])
        |=> !adapter_read_strobe_n_ff ##1 (adapter_read_strobe_n_ff || $past(io_rd) || $past(base_wr)))
        else $error("Matching read gave no read strobe");

    // ----------------------------------------
    // UART clocks, pin roles, parallel port
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            uart1_divisor_ff       <= `IOCPR_DIV_NORMAL;
            uart2_divisor_ff       <= `IOCPR_DIV_NORMAL;
            epp_revision_select_ff <= 1'b1;
            ecp_fifo_level_ff      <= 4'h0;
        end else begin
            uart1_divisor_ff       <= uart_pin_ff[`IOCPR_BIT_UART1_MID] ? `IOCPR_DIV_MIDI : `IOCPR_DIV_NORMAL;
            uart2_divisor_ff       <= uart_pin_ff[`IOCPR_BIT_UART2_MID] ? `IOCPR_DIV_MIDI : `IOCPR_DIV_NORMAL;
            epp_revision_select_ff <= uart_pin_ff[`IOCPR_BIT_EPP_REV];
            ecp_fifo_level_ff      <= ecp_ff;
        end
    end

    // Shared pins carry game strobes only when the DMA bit permits
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_role_game_ff <= 1'b0;
            pin41_ff         <= 1'b0;
            pin39_ff         <= 1'b0;
        end else begin
            pin_role_game_ff <= game_dma_request_bit && uart_pin_ff[`IOCPR_BIT_PIN_ROLE];
            pin41_ff <= (game_dma_request_bit && uart_pin_ff[`IOCPR_BIT_PIN_ROLE])
                        ? game_read_strobe : portable_floppy_enable;
            pin39_ff <= (game_dma_request_bit && uart_pin_ff[`IOCPR_BIT_PIN_ROLE])
                        ? game_write_strobe : portable_ext_enable;
        end
    end

    AST_UART_DIV: assert property (@(posedge clk) disable iff (rst)
        ##1 uart1_divisor_ff == ($past(uart_pin_ff[1]) ? 4'hc : 4'hd))
        else $error("First UART divisor wrong");
    AST_PIN_ROLE: assert property (@(posedge clk) disable iff (rst)
        !game_dma_request_bit |=> !pin_role_game_ff && (pin41_ff == $past(portable_floppy_enable)))
        else $error("Pin role ignored DMA precedence");

    // ----------------------------------------
    // Per-function power-down and float
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            par_power_down_ff      <= 1'b0;
            game_power_down_ff     <= 1'b0;
            uart1_power_down_ff    <= 1'b0;
            uart2_power_down_ff    <= 1'b0;
            par_float_outputs_ff   <= 1'b0;
            game_float_outputs_ff  <= 1'b0;
            uart1_float_outputs_ff <= 1'b0;
            uart2_float_outputs_ff <= 1'b0;
        end else begin
            {par_power_down_ff, game_power_down_ff,
             uart1_power_down_ff, uart2_power_down_ff} <= port_pwr_ff[7:4];
            {par_float_outputs_ff, game_float_outputs_ff,
             uart1_float_outputs_ff, uart2_float_outputs_ff} <= port_pwr_ff[7:4] & port_pwr_ff[3:0];
        end
    end

    // Floppy and disk interface power controls
    always_ff @(posedge clk) begin
        if (rst) begin
            floppy_pullup_off_ff     <= 1'b0;
            floppy_power_down_ff     <= 1'b0;
            disk_if_power_down_ff    <= 1'b0;
            floppy_float_outputs_ff  <= 1'b0;
            disk_if_float_outputs_ff <= 1'b0;
        end else begin
            floppy_pullup_off_ff     <= floppy_ff[`IOCPR_BIT_PULLUP];
            floppy_power_down_ff     <= floppy_ff[`IOCPR_BIT_FDC_PD];
            disk_if_power_down_ff    <= floppy_ff[`IOCPR_BIT_IDE_PD];
            floppy_float_outputs_ff  <= floppy_ff[`IOCPR_BIT_FDC_PD] && floppy_ff[`IOCPR_BIT_FDC_TRI];
            disk_if_float_outputs_ff <= floppy_ff[`IOCPR_BIT_IDE_PD] && floppy_ff[`IOCPR_BIT_IDE_TRI];
        end
    end

    AST_PORT_FLOAT: assert property (@(posedge clk) disable iff (rst)
        !port_pwr_ff[7] |=> !par_float_outputs_ff)
        else $error("Parallel port floated while powered");
    AST_RSVD_READ: assert property (@(posedge clk) disable iff (rst)
        cfg_rd && index_ff == `IOCPR_IDX_ECP |=> io_rdata_ff[7:4] == 4'h0)
        else $error("Reserved bits read nonzero");

    // ----------------------------------------
    // Drive select and motor encoding
    // ----------------------------------------
    // Swap exchanges drive A and B requests before decoding
    always_comb begin
        eff_dor = dor;
        if (drive_swap_ff) begin
            eff_dor[5:4] = {dor[4], dor[5]};
            if (dor[1] == 1'b0) begin
                eff_dor[0] = !dor[0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            drive_select_line0_n_ff <= 1'b1;
            drive_select_line1_n_ff <= 1'b1;
            motor_line0_n_ff        <= 1'b1;
            motor_line1_n_ff        <= 1'b1;
        end else if (floppy_ff[`IOCPR_BIT_FOUR_DRV]) begin
            drive_select_line0_n_ff <= eff_dor[0];
            drive_select_line1_n_ff <= eff_dor[1];
            motor_line0_n_ff        <= !eff_dor[3'd4 + {1'b0, eff_dor[1:0]}];
            motor_line1_n_ff        <= !eff_dor[3'd4 + {1'b0, eff_dor[1:0]}];
        end else begin
            drive_select_line0_n_ff <= !(eff_dor[4] && eff_dor[1:0] == 2'b00);
            motor_line0_n_ff        <= !(eff_dor[4] && eff_dor[1:0] == 2'b00);
            drive_select_line1_n_ff <= !(eff_dor[5] && eff_dor[1:0] == 2'b01);
            motor_line1_n_ff        <= !(eff_dor[5] && eff_dor[1:0] == 2'b01);
        end
    end

    AST_TWO_DRIVE_A: assert property (@(posedge clk) disable iff (rst)
        !floppy_ff[5] && !drive_swap_ff && dor == 8'h10
        |=> !drive_select_line0_n_ff && !motor_line0_n_ff && drive_select_line1_n_ff && motor_line1_n_ff)
        else $error("Two-drive decode of drive A wrong");
    AST_SWAP_A: assert property (@(posedge clk) disable iff (rst)
        !floppy_ff[5] && drive_swap_ff && dor == 8'h10
        |=> drive_select_line0_n_ff && !drive_select_line1_n_ff && !motor_line1_n_ff)
        else $error("Swap did not move drive A to B lines");
    AST_FOUR_DRIVE_C: assert property (@(posedge clk) disable iff (rst)
        floppy_ff[5] && dor == 8'h42
        |=> !motor_line0_n_ff && !motor_line1_n_ff && drive_select_line1_n_ff && !drive_select_line0_n_ff)
        else $error("Four-drive encode of drive C wrong");
endmodule : iocpr_regs

//--- test/iocpr_host_model.sv
// Host processor model for the configuration index and data ports
`timescale 1ns/1ps
module iocpr_host_model (
    // Host bus
    input  wire logic       clk,
    output logic [9:0]      io_addr,
    output logic [7:0]      io_wdata,
    output logic            io_wr,
    output logic            io_rd,
    input  wire logic [7:0] io_rdata_ff
);
    // One write cycle; released lines show the inverse
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(negedge clk);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge clk);
        io_wr = 1'b0;
        io_addr = ~a;
        io_wdata = ~d;
    endtask : wr
    // One read cycle; data taken half a cycle after the read edge
    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        @(negedge clk);
        io_addr = a;
        io_rd = 1'b1;
        @(negedge clk);
        io_rd = 1'b0;
        io_addr = ~a;
        d = io_rdata_ff;
    endtask : rd
    // Index first, then data
    task automatic cfg_wr(input logic [7:0] i, input logic [7:0] d);
        wr(10'h251, i);
        wr(10'h252, d);
    endtask : cfg_wr
    task automatic cfg_rd(input logic [7:0] i, output logic [7:0] d);
        wr(10'h251, i);
        rd(10'h252, d);
    endtask : cfg_rd
    initial begin
        io_addr = 10'h000;
        io_wdata = 8'h00;
        io_wr = 1'b0;
        io_rd = 1'b0;
    end
endmodule : iocpr_host_model

//--- test/io_config_power_regs_tb.sv
// Self-checking bench for the configuration bank
`timescale 1ns/1ps
module io_config_power_regs_tb;
    import iocpr_pkg::*;
    logic clk, rst, ext_mode, idle_ok, gdma;
    logic [7:0] dor, d;
    logic [3:0] src;
    logic [9:0] a;
    logic [7:0] wd, rdat, adat;
    logic wr, rd, stp, rs_n, ws_n, epp, ppd, pfl, ffl, p41, p39, ds0, ds1, m0, m1;
    logic [2:0] psel;
    logic [3:0] u1, u2, ecp;
    logic [10:0] pw;
    int error_cnt, n_tests, cyc;
    iocpr_host_model host (.clk(clk), .io_addr(a), .io_wdata(wd), .io_wr(wr), .io_rd(rd), .io_rdata_ff(rdat));
    iocpr_regs #(.APD_CYCLES(8)) dut (.clk(clk), .rst(rst), .ext_mode(ext_mode), .io_addr(a), .io_wdata(wd),
        .io_wr(wr), .io_rd(rd), .io_rdata_ff(rdat), .idle_ok(idle_ok), .prt_mode_hi(1'b0),
        .game_dma_request_bit(gdma), .dor(dor), .portable_floppy_enable(src[3]), .portable_ext_enable(src[2]),
        .game_read_strobe(src[1]), .game_write_strobe(src[0]), .internal_clock_stop_ff(stp),
        .power_select_ff(psel), .adapter_read_strobe_n_ff(rs_n), .adapter_write_strobe_n_ff(ws_n),
        .adapter_data_ff(adat), .uart1_divisor_ff(u1), .uart2_divisor_ff(u2), .pin41_ff(p41), .pin39_ff(p39),
        .pin_role_game_ff(pw[10]), .epp_revision_select_ff(epp), .ecp_fifo_level_ff(ecp), .par_power_down_ff(ppd),
        .game_power_down_ff(pw[9]), .uart1_power_down_ff(pw[8]), .uart2_power_down_ff(pw[7]),
        .par_float_outputs_ff(pfl), .game_float_outputs_ff(pw[6]), .uart1_float_outputs_ff(pw[5]),
        .uart2_float_outputs_ff(pw[4]), .floppy_pullup_off_ff(pw[3]), .floppy_power_down_ff(pw[2]),
        .disk_if_power_down_ff(pw[1]), .floppy_float_outputs_ff(ffl), .disk_if_float_outputs_ff(pw[0]),
        .drive_select_line0_n_ff(ds0),
        .drive_select_line1_n_ff(ds1), .motor_line0_n_ff(m0), .motor_line1_n_ff(m1));
    // Compare one byte-wide result
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic do_reset();
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
    endtask : do_reset
    // Reset values, reserved bits, decoded outputs
    task automatic t_regs();
        logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h30, 8'h00, 8'h00, 8'h00};
        logic [7:0] mk [6] = '{8'h80, 8'hff, 8'h33, 8'hff, 8'h0f, 8'h7f};
        for (int i = 0; i < 6; i++) begin
            host.cfg_rd(8'(i + 1), d);
            chk(d, rv[i]);
            host.cfg_wr(8'(i + 1), 8'hff);
            host.cfg_rd(8'(i + 1), d);
            chk(d, mk[i]);
        end
        chk({u1, u2}, 8'hcc);
        chk({epp, ecp, ppd, pfl, ffl}, 8'hff);
        chk(8'(pw[9:4]), 8'h3f);
        chk(8'(pw[3:0]), 8'h0f);
        host.cfg_wr(8'h04, 8'hf0);
        host.cfg_wr(8'h06, 8'h08);
        @(negedge clk);
        chk({ppd, pfl, ffl}, 8'h04);
        chk(8'(pw[9:4]), 8'h38);
        chk(8'(pw[3:0]), 8'h04);
    endtask : t_regs
    // Drive select and motor encoding
    task automatic t_drive();
        dor = 8'h10;
        host.cfg_wr(8'h06, 8'h00);
        @(negedge clk);
        chk({ds1, ds0, m1, m0}, 8'h0a);
        host.cfg_wr(8'h01, 8'h80);
        @(negedge clk);
        chk({ds1, ds0, m1, m0}, 8'h05);
        host.cfg_wr(8'h01, 8'h00);
        dor = 8'h83;
        host.cfg_wr(8'h06, 8'h20);
        @(negedge clk);
        chk({ds1, ds0, m1, m0}, 8'h0c);
        dor = 8'h42;
        @(negedge clk);
        chk({ds1, ds0, m1, m0}, 8'h08);
    endtask : t_drive
    // Adapter base latch and address match
    task automatic t_adapter();
        host.cfg_wr(8'h00, 8'h08);
        host.cfg_wr(8'h02, 8'h40);
        chk({rs_n, ws_n}, 8'h00);
        chk(adat, 8'h40);
        host.wr(10'h100, 8'h5a);
        chk({rs_n, ws_n}, 8'h02);
        host.rd(10'h107, d);
        chk({rs_n, ws_n}, 8'h01);
        host.rd(10'h108, d);
        chk({rs_n, ws_n}, 8'h03);
        host.cfg_wr(8'h02, 8'h41);
        host.rd(10'h108, d);
        chk({rs_n, ws_n}, 8'h01);
    endtask : t_adapter
    // Shared pin roles against the game DMA bit
    task automatic t_pins();
        repeat (2) @(negedge clk);
        chk({p41, p39, pw[10]}, 8'h04);
        gdma = 1'b1;
        repeat (2) @(negedge clk);
        chk({p41, p39, pw[10]}, 8'h03);
    endtask : t_pins
    // Automatic power-down entry, restart and wake
    task automatic t_apd();
        host.cfg_wr(8'h00, 8'h02);
        idle_ok = 1'b1;
        repeat (6) @(negedge clk);
        idle_ok = 1'b0;
        @(negedge clk);
        idle_ok = 1'b1;
        repeat (6) @(negedge clk);
        chk({stp, psel}, 8'h02);
        repeat (6) @(negedge clk);
        chk({stp, psel}, 8'h0b);
        idle_ok = 1'b0;
        repeat (2) @(negedge clk);
        chk({stp, psel}, 8'h02);
        host.cfg_rd(8'h00, d);
        chk(d, 8'h02);
    endtask : t_apd
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop
    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    initial begin
        {ext_mode, idle_ok, gdma, dor, src, error_cnt, n_tests, cyc} = '0;
        src = 4'b1001;
        ext_mode = 1'b1;
        do_reset();
        t_regs();
        do_reset();
        t_drive();
        t_adapter();
        t_pins();
        do_reset();
        t_apd();
        report_and_stop();
    end
endmodule : io_config_power_regs_tb
